// ===== logic/tpc_pkg.sv
// tpc_pkg: constants for the timer output pin control block
// assumes a single 100 MHz clock domain and an APB register slave
// Overview of operation
// - the software one-shot trigger bit always reads back as zero
// - writing one to the one-shot trigger clears, restarts counter and starts one pulse
// - one-shot mode select: zero successive pulses, one single pulse; setting it restarts counter
// - one-shot pulses work in free-running and external-edge clear-and-start modes
// - no one-shot pulse is produced in compare-0 clear-and-start mode
// - match-1 inversion enable set toggles output on each compare-1 match while one-shot mode select is zero
// - match-1 interrupt pulses on every compare-1 match regardless of inversion enable
// - match-0 inversion enable set toggles output on each compare-0 match while one-shot mode select is zero
// - match-0 interrupt pulses on every compare-0 match regardless of inversion enable
// - channels zero and one allow only the software one-shot trigger
// - level triggers: 00 no change, 01 force low, 10 force high, 11 prohibited
// - level bits are one-time triggers; clearing them leaves the output unchanged
// - level trigger bits always read back as zero
// - output disabled holds the pin low; enabled pin follows internal output state
// - reset clears the output control register to all zeros
// - mode 00 stopped and cleared, 01 free-run, 10 edge restart, 11 compare-0 restart
package tpc_pkg;
  localparam logic [11:0] TPC_ADDR_CTRL = 12'h000;
  localparam logic [11:0] TPC_ADDR_MODE = 12'h004;
  localparam logic [11:0] TPC_ADDR_STAT = 12'h008;
  localparam logic [11:0] TPC_ADDR_COUNT = 12'h00C;
  localparam logic [11:0] TPC_ADDR_CMP0 = 12'h010;
  localparam logic [11:0] TPC_ADDR_CMP1 = 12'h014;
  localparam int TPC_REG_COUNT = 6;
  localparam int TPC_IDX_BITS = 3;
  localparam logic [7:0] TPC_CTRL_RESET = 8'h00;
  localparam int TPC_B_OUT_EN = 0;
  localparam int TPC_B_INV0 = 1;
  localparam int TPC_B_LVL_RST = 2;
  localparam int TPC_B_LVL_SET = 3;
  localparam int TPC_B_INV1 = 4;
  localparam int TPC_B_OS_MODE = 5;
  localparam int TPC_B_OS_TRIG = 6;
  localparam logic [7:0] TPC_CTRL_RD_MASK = 8'h33;
  localparam logic [1:0] TPC_MODE_STOP = 2'h0;
  localparam logic [1:0] TPC_MODE_FREE = 2'h1;
  localparam logic [1:0] TPC_MODE_EDGE = 2'h2;
  localparam logic [1:0] TPC_MODE_CMP0 = 2'h3;
  localparam logic [15:0] TPC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TPC_CNT_ONE = 16'h0001;
  localparam logic [31:0] TPC_RD_ZERO = 32'h00000000;
  typedef enum logic [2:0] {
    TPC_OS_IDLE = 3'b001,
    TPC_OS_WAIT = 3'b010,
    TPC_OS_PULSE = 3'b100
  } tpc_os_state_t;
endpackage

// ===== logic/tpc_regs.sv
// tpc_regs: small register store for the compare words
// assumes a single clock and one write port; read data are registered
`timescale 1ns/100ps
`default_nettype none
module tpc_regs #(
  parameter int DEPTH = 4,
  parameter int AW = 2,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // read port
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];

  // storage, cleared by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ===== logic/tpc_timer_out.sv
// tpc_timer_out: one timer channel with its output pin control logic
// assumes synchronous inputs on mclk and an APB master with 32-bit data
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_out #(
  parameter int CHANNEL = 4,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count tick and external input valid edge
  input wire logic countTick,
  input wire logic extEdge,
  // timer events and pin
  output logic match0_irq,
  output logic match1_irq,
  output logic timer_out_pin
);
  import tpc_pkg::*;

  logic [7:0] timer_output_ctrl;
  logic [1:0] opMode;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] cmp_cap_reg0;
  logic [CW-1:0] cmp_cap_reg1;
  logic outState;
  logic osRestart;
  logic match0;
  logic match1;
  logic wrAccess;
  logic setupRd;
  logic [1:0] memIdx;
  logic [CW-1:0] memRd;
  tpc_os_state_t osState;
  tpc_os_state_t next_osState;

  // word offset decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // true on channels that can make one-shot pulses
  function automatic logic osCapable(input int ch);
    return !(ch == 2 || ch == 3);
  endfunction

  assign wrAccess = psel && penable && pwrite && pready;
  assign setupRd = psel && !penable && !pwrite;
  assign match0 = (opMode != TPC_MODE_STOP) && (count_reg == cmp_cap_reg0);
  assign match1 = (opMode != TPC_MODE_STOP) && (count_reg == cmp_cap_reg1);

  // compare words mirrored in a small memory whose read data memRd go unused
  always_comb begin
    memIdx = 2'h0;
    if (hit(paddr, TPC_ADDR_CMP1)) begin
      memIdx = 2'h1;
    end
  end

  tpc_regs #(
    .DEPTH(4),
    .AW(2),
    .DW(CW)
  ) u_regs (
    .mclk(mclk),
    .rst(rst),
    .wrEn(wrAccess && (hit(paddr, TPC_ADDR_CMP0) || hit(paddr, TPC_ADDR_CMP1))),
    .wrAddr(hit(paddr, TPC_ADDR_CMP1) ? 2'h1 : 2'h0),
    .wrData(pwdata[CW-1:0]),
    .rdAddr(memIdx),
    .rdData(memRd)
  );

  // ready one cycle after setup so registered read data are in place
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // read data captured in the setup cycle; level and one-shot triggers read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= TPC_RD_ZERO;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !(hit(paddr, TPC_ADDR_CTRL) || hit(paddr, TPC_ADDR_MODE)
                   || hit(paddr, TPC_ADDR_STAT) || hit(paddr, TPC_ADDR_COUNT)
                   || hit(paddr, TPC_ADDR_CMP0) || hit(paddr, TPC_ADDR_CMP1));
      prdata <= TPC_RD_ZERO;
      if (setupRd) begin
        if (hit(paddr, TPC_ADDR_CTRL)) begin
          prdata <= {24'h000000, timer_output_ctrl & TPC_CTRL_RD_MASK};
        end else if (hit(paddr, TPC_ADDR_MODE)) begin
          prdata <= {30'h00000000, opMode};
        end else if (hit(paddr, TPC_ADDR_STAT)) begin
          prdata <= {29'h00000000, osState != TPC_OS_IDLE, timer_out_pin, outState};
        end else if (hit(paddr, TPC_ADDR_COUNT)) begin
          prdata <= {{(32-CW){1'b0}}, count_reg};
        end
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // compare registers loaded by writes; reads of the compare words return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp_cap_reg0 <= '0;
      cmp_cap_reg1 <= '0;
    end else if (wrAccess && hit(paddr, TPC_ADDR_CMP0)) begin
      cmp_cap_reg0 <= pwdata[CW-1:0];
    end else if (wrAccess && hit(paddr, TPC_ADDR_CMP1)) begin
      cmp_cap_reg1 <= pwdata[CW-1:0];
    end
  end

  // output control register; trigger bits store the write but read as zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_output_ctrl <= TPC_CTRL_RESET;
    end else if (wrAccess && hit(paddr, TPC_ADDR_CTRL)) begin
      timer_output_ctrl <= pwdata[7:0];
      if (!osCapable(CHANNEL)) begin
        timer_output_ctrl[TPC_B_OS_MODE] <= 1'b0;
        timer_output_ctrl[TPC_B_OS_TRIG] <= 1'b0;
      end
    end else begin
      timer_output_ctrl[TPC_B_OS_TRIG] <= 1'b0;
      timer_output_ctrl[TPC_B_LVL_SET] <= 1'b0;
      timer_output_ctrl[TPC_B_LVL_RST] <= 1'b0;
    end
  end

  // operating mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      opMode <= TPC_MODE_STOP;
    end else if (wrAccess && hit(paddr, TPC_ADDR_MODE)) begin
      opMode <= pwdata[1:0];
    end
  end

  // one-shot restart: software trigger, or mode select rising to one
  always_comb begin
    osRestart = 1'b0;
    if (wrAccess && hit(paddr, TPC_ADDR_CTRL) && osCapable(CHANNEL)
        && opMode != TPC_MODE_STOP) begin
      osRestart = pwdata[TPC_B_OS_TRIG];
      if (pwdata[TPC_B_OS_MODE] && !timer_output_ctrl[TPC_B_OS_MODE]) begin
        osRestart = 1'b1;
      end
    end
  end

  // counter with mode-dependent clear and start
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= TPC_CNT_ZERO;
    end else begin
      case (opMode)
        TPC_MODE_STOP: count_reg <= TPC_CNT_ZERO;
        TPC_MODE_FREE: begin
          if (osRestart) begin
            count_reg <= TPC_CNT_ZERO;
          end else if (countTick) begin
            count_reg <= count_reg + TPC_CNT_ONE;
          end
        end
        TPC_MODE_EDGE: begin
          if (osRestart || (extEdge && !(CHANNEL == 0 || CHANNEL == 1))) begin
            count_reg <= TPC_CNT_ZERO;
          end else if (countTick) begin
            count_reg <= count_reg + TPC_CNT_ONE;
          end
        end
        TPC_MODE_CMP0: begin
          if (osRestart || (match0 && countTick)) begin
            count_reg <= TPC_CNT_ZERO;
          end else if (countTick) begin
            count_reg <= count_reg + TPC_CNT_ONE;
          end
        end
        default: count_reg <= TPC_CNT_ZERO;
      endcase
    end
  end

  // one-shot sequencer: wait for compare 0 to go high, compare 1 to go low
  always_comb begin
    next_osState = osState;
    case (osState)
      TPC_OS_IDLE: begin
        if (osRestart && opMode != TPC_MODE_CMP0) begin
          next_osState = TPC_OS_WAIT;
        end
      end
      TPC_OS_WAIT: begin
        if (match0 && countTick) begin
          next_osState = TPC_OS_PULSE;
        end
      end
      TPC_OS_PULSE: begin
        if (match1 && countTick) begin
          next_osState = TPC_OS_IDLE;
        end
      end
      default: next_osState = TPC_OS_IDLE;
    endcase
    if (opMode == TPC_MODE_STOP || opMode == TPC_MODE_CMP0) begin
      next_osState = TPC_OS_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      osState <= TPC_OS_IDLE;
    end else begin
      osState <= next_osState;
    end
  end

  // internal output state; level triggers first, then match inversions
  always_ff @(posedge mclk) begin
    if (rst) begin
      outState <= 1'b0;
    end else if (wrAccess && hit(paddr, TPC_ADDR_CTRL)
                 && pwdata[TPC_B_LVL_SET] != pwdata[TPC_B_LVL_RST]) begin
      outState <= pwdata[TPC_B_LVL_SET];
    end else if (timer_output_ctrl[TPC_B_OS_MODE] && osCapable(CHANNEL)) begin
      if (osState == TPC_OS_WAIT && match0 && countTick) begin
        outState <= 1'b1;
      end else if (osState == TPC_OS_PULSE && match1 && countTick) begin
        outState <= 1'b0;
      end
    end else if (countTick) begin
      outState <= outState
                  ^ (match0 && timer_output_ctrl[TPC_B_INV0])
                  ^ (match1 && timer_output_ctrl[TPC_B_INV1]);
    end
  end

  // pin level taken from the internal output state
  function automatic logic next_pin(input logic s);
    return s;
  endfunction

  // pin gated by the output enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_out_pin <= 1'b0;
    end else begin
      timer_out_pin <= timer_output_ctrl[TPC_B_OUT_EN] ? next_pin(outState) : 1'b0;
    end
  end

  // match interrupts, one pulse per match tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      match0_irq <= 1'b0;
      match1_irq <= 1'b0;
    end else begin
      match0_irq <= match0 && countTick;
      match1_irq <= match1 && countTick;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tpc_pin_load.sv
// tpc_pin_load: model of the circuit fed by the timer output pin
// assumes the pin is a registered level on mclk
`timescale 1ns/100ps
`default_nettype none
module tpc_pin_load (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin and counted edges
  input wire logic pinIn,
  output logic [7:0] riseCount
);
  logic lastLevel;
  // counts rising edges, as a pulse counter on the pin would
  always_ff @(posedge mclk) begin
    if (rst) begin
      lastLevel <= 1'b0;
      riseCount <= 8'h00;
    end else begin
      lastLevel <= pinIn;
      if (pinIn && !lastLevel) begin
        riseCount <= riseCount + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tpc_timer_out_asserts.sv
// tpc_timer_out_asserts: port checks for the timer output block
// assumes one clock mclk and a synchronous active-high rst
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_out_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and pin
  input wire logic countTick,
  input wire logic match0_irq,
  input wire logic match1_irq,
  input wire logic timer_out_pin
);
  import tpc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // completed accesses
  wire logic rdCtl = psel && penable && pready && !pwrite && paddr == TPC_ADDR_CTRL;
  wire logic wrAcc = psel && penable && pready && pwrite;
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable; endsequence
  a_access_wait: assert property (s_setup ##1 s_acc |-> pready)
    else $error("no ready in access cycle");
  a_ready_alone: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_trig_readzero: assert property (rdCtl |-> !prdata[TPC_B_OS_TRIG])
    else $error("trigger bit read as one");
  a_lvl_readzero: assert property (rdCtl |-> prdata[3:2] == 2'h0)
    else $error("level bits read as one");
  a_unmapped_err: assert property (s_acc and pready && paddr > 12'h014
    |-> pslverr && (pwrite || prdata == TPC_RD_ZERO))
    else $error("unmapped access not refused");
  a_irq0_tick: assert property (match0_irq |-> $past(countTick))
    else $error("match0 event without tick");
  a_irq1_tick: assert property (match1_irq |-> $past(countTick))
    else $error("match1 event without tick");
  a_reset_low: assert property ($fell(rst) |-> !timer_out_pin && !match0_irq)
    else $error("outputs not cleared by reset");
  a_pin_cause: assert property ($changed(timer_out_pin) |-> $past(match0_irq)
    || $past(match1_irq) || match0_irq || match1_irq
    || $past(wrAcc) || $past(wrAcc, 2) || $past(wrAcc, 3))
    else $error("pin moved without cause");
endmodule
bind tpc_timer_out tpc_timer_out_asserts i_tpc_timer_out_asserts (.mclk, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .countTick, .match0_irq,
  .match1_irq, .timer_out_pin);
`default_nettype wire

// ===== verification/tb.sv
// tb: self-checking bench for tpc_timer_out with an apb master
// assumes the pin load model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tpc_pkg::*;
  logic mclk, rst, psel, penable, pwrite, countTick, extEdge, pready, pslverr;
  logic match0_irq, match1_irq, timer_out_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] riseCount, base, cfg;
  logic [32:0] expQ[$];
  int num_errors, check_count, cycles, n0, n1, seed, ticks;
  logic [8:0] lv [8] = '{9'h012, 9'h013, 9'h11B, 9'h113, 9'h11F, 9'h012, 9'h113, 9'h017};
  logic [15:0] runs [6] = '{16'h5903, 16'h5113, 16'h4101, 16'h5521, 16'h5621, 16'h0721};
  tpc_timer_out i_tpc_timer_out (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .countTick, .extEdge, .match0_irq, .match1_irq,
    .timer_out_pin);
  tpc_pin_load i_tpc_pin_load (.mclk, .rst, .pinIn(timer_out_pin), .riseCount);
  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one apb transfer; a read notes {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge mclk);
    if (!w) expQ.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read monitor and event counters
  always @(posedge mclk) begin
    n0 += int'(match0_irq === 1'b1);
    n1 += int'(match1_irq === 1'b1);
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("read", expQ.pop_front(), {pslverr, prdata});
    end
  end
  // timeout
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    seed = 76729;
    rst = 1'b1;
    {psel, penable, pwrite, countTick, extEdge} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, TPC_ADDR_CTRL, 32'h0, 33'h0);
    apb(1'b1, TPC_ADDR_CMP0, 32'h3, 33'h0);
    apb(1'b1, TPC_ADDR_CMP1, 32'h7, 33'h0);
    apb(1'b0, 12'h020, 32'h0, 33'h100000000);
    foreach (lv[i]) begin
      apb(1'b1, TPC_ADDR_CTRL, {24'h0, lv[i][7:0]}, 33'h0);
      repeat (3) @(negedge mclk);
      chk("level", {32'h0, lv[i][8]}, {32'h0, timer_out_pin});
    end
    foreach (runs[i]) begin
      cfg = runs[i][7:0];
      apb(1'b1, TPC_ADDR_MODE, 32'h0, 33'h0);
      apb(1'b0, TPC_ADDR_COUNT, 32'h0, 33'h0);
      apb(1'b1, TPC_ADDR_CTRL, {24'h0, cfg}, 33'h0);
      apb(1'b1, TPC_ADDR_CTRL, {24'h0, cfg | 8'h04}, 33'h0);
      apb(1'b1, TPC_ADDR_MODE, {30'h0, runs[i][9:8]}, 33'h0);
      if (runs[i][10]) apb(1'b1, TPC_ADDR_CTRL, {24'h0, cfg | 8'h40}, 33'h0);
      base = riseCount;
      n0 = 0;
      n1 = 0;
      ticks = 0;
      while (ticks < 12) begin
        @(posedge mclk);
        r = $random(seed);
        countTick <= r[0];
        extEdge <= r[1] & (runs[i][9:8] == 2'h1);
        ticks += int'(r[0]);
      end
      @(posedge mclk);
      countTick <= 1'b0;
      extEdge <= 1'b0;
      repeat (4) @(negedge mclk);
      chk("pin", {32'h0, runs[i][11]}, {32'h0, timer_out_pin});
      chk("rises", {31'h0, runs[i][13:12]}, {25'h0, riseCount - base});
      if (runs[i][14]) begin
        chk("irq0", 33'h1, 33'(n0));
        chk("irq1", 33'h1, 33'(n1));
        apb(1'b0, TPC_ADDR_COUNT, 32'h0, 33'h00C);
      end
      apb(1'b0, TPC_ADDR_CTRL, 32'h0, {25'h0, cfg & 8'h33});
    end
    wrap_up();
  end
endmodule
`default_nettype wire
